//--- rtl/sync_rx_defs.vh
// constants for the synchronous serial receiver
// assumes a 32-bit apb bus and byte addressed word registers
`ifndef SYNC_RX_DEFS_VH
`define SYNC_RX_DEFS_VH
// register byte offsets
`define OFS_RXCTL 8'h00
`define OFS_TXCTL 8'h04
`define OFS_RXDATA 8'h08
`define OFS_BAUD 8'h0C
`define OFS_STAT 8'h10
// receive_status_control fields
`define B_PORT_EN 7
`define B_NINE_SEL 6
`define B_SINGLE_EN 5
`define B_CONT_EN 4
`define B_OVERRUN 1
`define B_NINTH 0
// transmit_status_control fields
`define B_CLK_SRC 7
`define B_SYNC 4
// status fields
`define B_RDY 0
`define B_CNT_LO 1
`define B_CNT_HI 2
// reset values
`define RST_CTL 1'b0
`define RST_BAUD 16'h0004
`define RST_DATA 9'h000
// character lengths and fifo limits
`define BITS_8 4'h8
`define BITS_9 4'h9
`define CNT_EMPTY 2'h0
`define CNT_ONE 2'h1
`define CNT_FULL 2'h2
`define ZERO32 32'h00000000
`endif

//--- rtl/sync_serial_receiver.v
// synchronous receive path of a serial port with a two entry fifo
// assumes apb master on pclk; link pins are asynchronous to pclk
`timescale 1ns/1ps
`include "sync_rx_defs.vh"
module sync_serial_receiver #(
	parameter AW = 8,
	parameter DIVW = 16
)(
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [AW-1:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire shift_clock_in,
	output reg shift_clock_out,
	output reg shift_clock_oe,
	input wire serial_data_in,
	output reg serial_data_out,
	output reg serial_data_oe,
	output reg receive_ready_flag
);
	// control registers
	reg port_enable_reg;
	reg nine_bit_select_reg;
	reg single_receive_enable_reg;
	reg continuous_receive_enable_reg;
	reg clock_source_select_reg;
	reg sync_mode_reg;
	reg [DIVW-1:0] baud_div_reg;
	// receive state
	reg [8:0] receive_shift_register;
	reg [3:0] bit_cnt_reg;
	reg [DIVW-1:0] div_cnt_reg;
	reg ck_reg;
	reg [8:0] fifo_mem [0:1];
	reg rd_ptr_reg;
	reg [1:0] count_reg;
	reg overrun_error_bit;
	reg ovr_cont_reg;
	// pin synchronisers
	reg ck_s1;
	reg ck_s2;
	reg ck_s3;
	reg ck_lvl;
	reg dt_s1;
	reg dt_s2;
	reg dt_s3;
	reg dt_lvl;
	wire ck_s3_n;
	wire dt_now;
	wire ck_run;
	wire is_master;
	wire rx_on;
	wire tick;
	wire trailing;
	wire [3:0] char_bits;
	wire last_bit;
	wire done;
	wire [8:0] shift_next;
	wire [8:0] char_word;
	wire apb_setup;
	wire apb_access;
	wire wr_ctl;
	wire wr_tx;
	wire wr_baud;
	wire rd_data;
	wire pop;
	wire push;
	wire [8:0] head;
	wire mapped;
	reg [31:0] rdata_next;

	assign is_master = sync_mode_reg & clock_source_select_reg;
	// master clock may only run while reception runs
	assign ck_run = rx_on & is_master;
	// reception runs while port and sync mode are on, either enable is set and no overrun pends
	assign rx_on = port_enable_reg & sync_mode_reg & ~overrun_error_bit &
		(single_receive_enable_reg | continuous_receive_enable_reg);
	assign tick = (div_cnt_reg == {DIVW{1'b0}});
	assign ck_s3_n = ~ck_s3;
	// trailing edge: falling edge of the shift clock
	assign trailing = is_master ? (tick & ck_reg) :
		(ck_lvl & ck_s3_n & (ck_s2 == ck_s3));
	assign char_bits = nine_bit_select_reg ? `BITS_9 : `BITS_8;
	assign last_bit = (bit_cnt_reg == char_bits - 4'h1);
	assign done = rx_on & trailing & last_bit;
	// data counts once the second and third stages agree
	assign dt_now = (dt_s2 == dt_s3) ? dt_s3 : dt_lvl;
	assign shift_next = {dt_now, receive_shift_register[8:1]};
	assign char_word = nine_bit_select_reg ? shift_next : {1'b0, shift_next[8:1]};
	assign head = fifo_mem[rd_ptr_reg];

	assign apb_setup = psel & ~penable;
	assign apb_access = psel & penable & pready;
	assign wr_ctl = apb_access & pwrite & (paddr == `OFS_RXCTL);
	assign wr_tx = apb_access & pwrite & (paddr == `OFS_TXCTL);
	assign wr_baud = apb_access & pwrite & (paddr == `OFS_BAUD);
	assign rd_data = apb_access & ~pwrite & (paddr == `OFS_RXDATA);
	assign pop = rd_data & (count_reg != `CNT_EMPTY) & port_enable_reg;
	assign push = done & (count_reg != `CNT_FULL);
	assign mapped = (paddr == `OFS_RXCTL) | (paddr == `OFS_TXCTL) |
		(paddr == `OFS_RXDATA) | (paddr == `OFS_BAUD) | (paddr == `OFS_STAT);

	// three stage synchronisers for the link pins
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ck_s1 <= 1'b0;
			ck_s2 <= 1'b0;
			ck_s3 <= 1'b0;
			ck_lvl <= 1'b0;
			dt_s1 <= 1'b0;
			dt_s2 <= 1'b0;
			dt_s3 <= 1'b0;
			dt_lvl <= 1'b0;
		end
		else
		begin
			ck_s1 <= shift_clock_in;
			ck_s2 <= ck_s1;
			ck_s3 <= ck_s2;
			if (ck_s2 == ck_s3)
				ck_lvl <= ck_s3;
			dt_s1 <= serial_data_in;
			dt_s2 <= dt_s1;
			dt_s3 <= dt_s2;
			if (dt_s2 == dt_s3)
				dt_lvl <= dt_s3;
		end
	end

	// control registers and hardware clear of single enable
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			port_enable_reg <= `RST_CTL;
			nine_bit_select_reg <= `RST_CTL;
			single_receive_enable_reg <= `RST_CTL;
			continuous_receive_enable_reg <= `RST_CTL;
			clock_source_select_reg <= `RST_CTL;
			sync_mode_reg <= `RST_CTL;
			baud_div_reg <= `RST_BAUD;
		end
		else
		begin
			if (wr_ctl)
			begin
				port_enable_reg <= pwdata[`B_PORT_EN];
				nine_bit_select_reg <= pwdata[`B_NINE_SEL];
				single_receive_enable_reg <= pwdata[`B_SINGLE_EN];
				continuous_receive_enable_reg <= pwdata[`B_CONT_EN];
			end
			else if (done)
				single_receive_enable_reg <= 1'b0;
			if (wr_tx)
			begin
				clock_source_select_reg <= pwdata[`B_CLK_SRC];
				sync_mode_reg <= pwdata[`B_SYNC];
			end
			if (wr_baud)
				baud_div_reg <= pwdata[DIVW-1:0];
		end
	end

	// baud divider and master shift clock
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			div_cnt_reg <= {DIVW{1'b0}};
			ck_reg <= 1'b0;
		end
		else if (!ck_run)
		begin
			// clock stops at once when reception ends
			div_cnt_reg <= baud_div_reg;
			ck_reg <= 1'b0;
		end
		else if (tick)
		begin
			div_cnt_reg <= baud_div_reg;
			if (!(done & ~continuous_receive_enable_reg))
				ck_reg <= ~ck_reg;
			else
				ck_reg <= 1'b0;
		end
		else
			div_cnt_reg <= div_cnt_reg - {{(DIVW-1){1'b0}}, 1'b1};
	end

	// receive shift register and bit counter
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			receive_shift_register <= `RST_DATA;
			bit_cnt_reg <= 4'h0;
		end
		else if (!rx_on)
		begin
			// partial character is discarded
			receive_shift_register <= `RST_DATA;
			bit_cnt_reg <= 4'h0;
		end
		else if (trailing)
		begin
			receive_shift_register <= shift_next;
			if (last_bit)
				bit_cnt_reg <= 4'h0;
			else
				bit_cnt_reg <= bit_cnt_reg + 4'h1;
		end
	end

	// two entry fifo and overrun handling
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			fifo_mem[0] <= `RST_DATA;
			fifo_mem[1] <= `RST_DATA;
			rd_ptr_reg <= 1'b0;
			count_reg <= `CNT_EMPTY;
			overrun_error_bit <= 1'b0;
			ovr_cont_reg <= 1'b0;
		end
		else if (!port_enable_reg)
		begin
			// port disable resets the receiver
			rd_ptr_reg <= 1'b0;
			count_reg <= `CNT_EMPTY;
			overrun_error_bit <= 1'b0;
			ovr_cont_reg <= 1'b0;
		end
		else
		begin
			if (push)
			begin
				if (count_reg == `CNT_EMPTY)
					fifo_mem[rd_ptr_reg] <= char_word;
				else
					fifo_mem[~rd_ptr_reg] <= char_word;
			end
			if (pop)
				rd_ptr_reg <= ~rd_ptr_reg;
			if (push & ~pop)
				count_reg <= count_reg + `CNT_ONE;
			else if (pop & ~push)
				count_reg <= count_reg - `CNT_ONE;
			if (done & (count_reg == `CNT_FULL))
			begin
				// stored characters are kept; set wins over clear
				overrun_error_bit <= 1'b1;
				ovr_cont_reg <= continuous_receive_enable_reg;
			end
			else if (overrun_error_bit & ~ovr_cont_reg & rd_data)
				overrun_error_bit <= 1'b0;
			else if (overrun_error_bit & ovr_cont_reg &
				~continuous_receive_enable_reg)
				overrun_error_bit <= 1'b0;
		end
	end

	// pin drivers and ready flag
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			shift_clock_out <= 1'b0;
			shift_clock_oe <= 1'b0;
			serial_data_out <= 1'b0;
			serial_data_oe <= 1'b0;
			receive_ready_flag <= 1'b0;
		end
		else
		begin
			shift_clock_out <= ck_reg & ck_run;
			// slave mode leaves the clock pin undriven
			shift_clock_oe <= port_enable_reg & is_master;
			serial_data_out <= 1'b0;
			serial_data_oe <= 1'b0;
			receive_ready_flag <= (count_reg != `CNT_EMPTY);
		end
	end

	// apb read mux
	always @*
	begin
		rdata_next = `ZERO32;
		case (paddr)
			`OFS_RXCTL:
			begin
				rdata_next[`B_PORT_EN] = port_enable_reg;
				rdata_next[`B_NINE_SEL] = nine_bit_select_reg;
				rdata_next[`B_SINGLE_EN] = single_receive_enable_reg;
				rdata_next[`B_CONT_EN] = continuous_receive_enable_reg;
				rdata_next[`B_OVERRUN] = overrun_error_bit;
				rdata_next[`B_NINTH] = head[8];
			end
			`OFS_TXCTL:
			begin
				rdata_next[`B_CLK_SRC] = clock_source_select_reg;
				rdata_next[`B_SYNC] = sync_mode_reg;
			end
			`OFS_RXDATA:
				rdata_next[7:0] = head[7:0];
			`OFS_BAUD:
				rdata_next[DIVW-1:0] = baud_div_reg;
			`OFS_STAT:
			begin
				rdata_next[`B_RDY] = (count_reg != `CNT_EMPTY);
				rdata_next[`B_CNT_HI:`B_CNT_LO] = count_reg;
			end
			default:
				rdata_next = `ZERO32;
		endcase
	end

	// apb slave: one wait-free access cycle after setup
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= `ZERO32;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else if (apb_setup & ~pready)
		begin
			prdata <= rdata_next;
			pready <= 1'b1;
			pslverr <= ~mapped;
		end
		else
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end
endmodule

//--- testbench/sync_serial_receiver_props.sv
// assertion checker for the synchronous serial receiver
// bound to the receiver top; sees only its ports
`timescale 1ns/1ps
module sync_serial_receiver_props #(
	parameter AW = 8
)(
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [AW-1:0] paddr,
	input wire [31:0] pwdata,
	input wire pready,
	input wire pslverr,
	input wire shift_clock_in,
	input wire shift_clock_out,
	input wire shift_clock_oe,
	input wire serial_data_out,
	input wire serial_data_oe,
	input wire receive_ready_flag
);
	logic [3:0] since;
	logic [2:0] hist;
	wire acc = psel & penable & pready;
	wire stop_wr = acc & pwrite & (paddr == '0) & (pwdata[5:4] == 2'h0);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// cycles since the last falling shift clock, either source
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			since <= 4'hF;
			hist <= 3'h0;
		end
		else
		begin
			hist <= {hist[1], shift_clock_in, shift_clock_out};
			if ((hist[0] & !shift_clock_out) | (hist[2] & !hist[1]))
				since <= 4'h0;
			else if (since != 4'hF)
				since <= since + 4'h1;
		end
	end
	sequence s_answer;
		pready ##1 !pready;
	endsequence
	sequence s_quiet;
		!shift_clock_out [*8];
	endsequence
	a_ready_pulse: assert property (psel && !penable |=> s_answer)
		else $error("pready not one cycle");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_data_off: assert property (!serial_data_oe && !serial_data_out)
		else $error("data pin driven");
	a_clock_idle: assert property (!shift_clock_oe |-> !shift_clock_out)
		else $error("clock out while not driving");
	a_oe_cause: assert property ($changed(shift_clock_oe) |-> $past(acc, 1) || $past(acc, 2))
		else $error("clock enable moved alone");
	a_flag_source: assert property ($rose(receive_ready_flag) |->
		$fell(shift_clock_out) || since < 4'hC)
		else $error("ready without clock fall");
	a_flag_fall: assert property ($fell(receive_ready_flag) |-> $past(acc, 1) || $past(acc, 2))
		else $error("ready fell without access");
	a_stop_now: assert property (stop_wr |=> ##1 s_quiet)
		else $error("clock kept running");
endmodule
bind sync_serial_receiver sync_serial_receiver_props #(.AW(AW)) props_i (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .shift_clock_in, .shift_clock_out,
	.shift_clock_oe, .serial_data_out, .serial_data_oe, .receive_ready_flag);

//--- testbench/serial_peer.sv
// behavioural far-side synchronous serial device
// drives the data pin; makes the link clock when the receiver is slave
`timescale 1ns/1ps
module serial_peer (
	input wire ck_pin,
	output logic data,
	output logic ck_drv
);
	logic [8:0] word = 9'h000;
	integer len = 8;
	integer n = 0;
	integer cnt = 0;
	initial
	begin
		data = 1'b0;
		ck_drv = 1'b0;
	end
	// next bit on the leading edge, lsb first
	always @(posedge ck_pin)
	begin
		data = word[n];
		n = (n + 1) % len;
	end
	// once hold is over the line no longer shows the bit
	always @(negedge ck_pin)
	begin
		cnt = cnt + 1;
		#30 data = ~data;
	end
	task load(input logic [8:0] v, input integer l);
		word = v;
		len = l;
		n = 0;
		cnt = 0;
	endtask
	task clocks(input integer k);
		repeat (k)
		begin
			#62.5 ck_drv = 1'b1;
			#62.5 ck_drv = 1'b0;
		end
	endtask
endmodule

//--- testbench/sync_serial_receiver_tb.sv
// self-checking bench for the synchronous serial receiver
// apb master here; serial_peer stands on the link
`timescale 1ns/1ps
`include "sync_rx_defs.vh"
module sync_serial_receiver_tb;
	logic pclk, presetn, psel, penable, pwrite, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, q;
	wire [31:0] prdata;
	wire pready, pslverr, ck_out, ck_oe, ck_in, d_out, d_oe, d_in, receive_ready_flag, pd, pck;
	integer mismatches = 0;
	integer comparisons = 0;
	assign ck_in = ck_oe ? ck_out : pck;
	assign d_in = d_oe ? d_out : pd;
	sync_serial_receiver sync_serial_receiver_i (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .shift_clock_in(ck_in),
		.shift_clock_out(ck_out), .shift_clock_oe(ck_oe), .serial_data_in(d_in),
		.serial_data_out(d_out), .serial_data_oe(d_oe), .receive_ready_flag);
	serial_peer serial_peer_i (.ck_pin(ck_in), .data(pd), .ck_drv(pck));
	task give_verdict;
		if (mismatches == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons = comparisons + 1;
		if (got !== exp)
		begin
			mismatches = mismatches + 1;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task flg(input logic e);
		chk({31'h0, receive_ready_flag}, {31'h0, e});
	endtask
	task hang;
		mismatches = mismatches + 1;
		$display("[ERR] %0t wait timed out", $time);
		give_verdict;
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		integer i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 50; i++)
		begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		if (i == 50)
			hang;
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask
	task falls(input integer k);
		integer i;
		for (i = 0; i < 5000 && serial_peer_i.cnt < k; i++)
			@(posedge pclk);
		if (i == 5000)
			hang;
	endtask
	task t_reset;
		chk({31'h0, d_oe}, 32'h0);
		apb(1'b0, `OFS_RXCTL, 32'h0);
		chk(q, 32'h0);
		apb(1'b0, `OFS_BAUD, 32'h0);
		chk(q, 32'h4);
		apb(1'b0, 8'h14, 32'h0);
		chk({31'h0, err}, 32'h1);
	endtask
	task t_single;
		apb(1'b1, `OFS_TXCTL, 32'h90);
		apb(1'b1, `OFS_BAUD, 32'h0C);
		serial_peer_i.load(9'h0A5, 8);
		apb(1'b1, `OFS_RXCTL, 32'hA0);
		chk({30'h0, d_oe, d_out}, 32'h0);
		chk({31'h0, ck_oe}, 32'h1);
		falls(8);
		repeat (100) @(posedge pclk);
		chk(serial_peer_i.cnt, 32'h8);
		flg(1'b1);
		apb(1'b0, `OFS_RXCTL, 32'h0);
		chk(q, 32'h80);
		apb(1'b0, `OFS_RXDATA, 32'h0);
		chk(q, 32'hA5);
		flg(1'b0);
	endtask
	task t_nine;
		logic [8:0] v [3];
		integer k;
		v = '{9'h1A5, 9'h05A, 9'h133};
		for (k = 0; k < 3; k++)
		begin
			serial_peer_i.load(v[k], 9);
			apb(1'b1, `OFS_RXCTL, 32'hE0);
			falls(9);
			repeat (60) @(posedge pclk);
		end
		apb(1'b0, `OFS_RXCTL, 32'h0);
		chk(q, 32'hC3);
		apb(1'b0, `OFS_RXDATA, 32'h0);
		chk(q, 32'hA5);
		apb(1'b0, `OFS_RXCTL, 32'h0);
		chk(q, 32'hC0);
		apb(1'b0, `OFS_RXDATA, 32'h0);
		chk(q, 32'h5A);
	endtask
	task t_cont;
		serial_peer_i.load(9'h03C, 8);
		apb(1'b1, `OFS_RXCTL, 32'hB0);
		falls(8);
		apb(1'b0, `OFS_RXCTL, 32'h0);
		chk(q, 32'h90);
		falls(19);
		apb(1'b1, `OFS_RXCTL, 32'h80);
		repeat (100) @(posedge pclk);
		chk(serial_peer_i.cnt, 32'h13);
		apb(1'b0, `OFS_RXDATA, 32'h0);
		chk(q, 32'h3C);
		apb(1'b0, `OFS_RXDATA, 32'h0);
		chk(q, 32'h3C);
		flg(1'b0);
	endtask
	task t_slave;
		logic [7:0] v [4];
		integer k;
		v = '{8'h96, 8'h69, 8'h0F, 8'hF0};
		apb(1'b1, `OFS_TXCTL, 32'h10);
		apb(1'b1, `OFS_RXCTL, 32'h90);
		chk({31'h0, ck_oe}, 32'h0);
		for (k = 0; k < 4; k++)
		begin
			serial_peer_i.load({1'b0, v[k]}, 8);
			serial_peer_i.clocks(8);
			repeat (20) @(posedge pclk);
		end
		apb(1'b0, `OFS_RXCTL, 32'h0);
		chk(q, 32'h92);
		apb(1'b0, `OFS_RXDATA, 32'h0);
		chk(q, 32'h96);
		apb(1'b0, `OFS_RXDATA, 32'h0);
		chk(q, 32'h69);
		flg(1'b0);
		apb(1'b1, `OFS_RXCTL, 32'h0);
		apb(1'b0, `OFS_RXCTL, 32'h0);
		chk(q, 32'h0);
	endtask
	initial
	begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_single;
		t_nine;
		t_cont;
		t_slave;
		give_verdict;
	end
endmodule
